// ---- include/lisc_regs.vh ----
// constants for the line interface serial control port
`ifndef LISC_REGS_VH
`define LISC_REGS_VH

// ----------
// register address and command byte
// ----------
`define LISC_REG_ADDR 6'h10
`define LISC_CMD_RD_BIT 0
`define LISC_CMD_ADDR_HI 6
`define LISC_CMD_ADDR_LO 1
`define LISC_CTRL_RESET 8'h00

// ----------
// data register fields
// ----------
`define LISC_B_CLR_LOS 0
`define LISC_B_DRIVER_FAULT_CLEAR 1
`define LISC_B_REACH_LO 2
`define LISC_B_REACH_HI 4
`define LISC_B_LINE_LB 5
`define LISC_B_FRM_LB 6
`define LISC_B_ALL_ONES 7

// ----------
// serial bit counts (rising edges of ser_clock)
// ----------
`define LISC_CNT_W 5
`define LISC_CNT_CMD_LAST 5'd7
`define LISC_CNT_WR_LAST 5'd15
`define LISC_CNT_RD_FIRST 5'd8
`define LISC_CNT_RD_END 5'd16
`define LISC_CNT_MAX 5'd17

// ----------
// timing
// ----------
`define LISC_CLK_MHZ 100
`define LISC_PWR_DELAY_MS 10
`define LISC_CAL_LIMIT_MS 20
`define LISC_CAL_LEN 2048
`define LISC_PIN_RST_NS 200
`define LISC_PIN_RST_CYC ((`LISC_PIN_RST_NS * `LISC_CLK_MHZ + 999) / 1000)
`define LISC_TMR_W 21
`define LISC_REF_GONE 8'hff

// ----------
// synchroniser lanes
// ----------
`define LISC_SYNC_W 14
`define LISC_S_SEL_N 0
`define LISC_S_SCLK 1
`define LISC_S_SIN 2
`define LISC_S_EDGE 3
`define LISC_S_LOS 4
`define LISC_S_DPM 5
`define LISC_S_HOST 6
`define LISC_S_LPIN 7
`define LISC_S_FPIN 8
`define LISC_S_PGOOD 9
`define LISC_S_XTAL 10
`define LISC_S_OSCDIS 11
`define LISC_S_ALTREF 12
`define LISC_S_TXCLK 13

// ----------
// power-up sequencer states
// ----------
`define LISC_ST_WAIT 2'd0
`define LISC_ST_CAL 2'd1
`define LISC_ST_RUN 2'd2

`endif

// ---- src/lisc_port.v ----
// host-mode serial control port with alarm events and reset/calibration sequencing
// Operation
// - transfer starts on select falling from high
// - command and write bits sampled on rising clock
// - bit 7 held to edge 16 or 17
// - output released when idle or finished
// - command lsb first, first bit direction
// - respond only to address sixteen
// - eight data bits follow command byte
// - written bits map clears, reach, loopbacks
// - alarm raised on signal loss or fault
// - clear bit clears, resets status, masks
// - reading never clears the pending alarm
// - zero in clear bit enables interrupt
// - line loopback with all-ones is test mode
// - read returns fault state and reach
// - no event: bits 5-6 show loopbacks, bit 7 all-ones
// - pending events coded 101 110 111
// - power-up delay then calibration, flagged late past its limit
// - calibration runs only with reference clocks
// - pin reset outside host mode: both pins high 200 ns
// - writing both loopbacks resets device
// - reset zeroes registers, centers osc, forces loss
// - output edge select picks valid edge
// - open-drain alarm stays until cleared
`timescale 1ns/1ns
`default_nettype none
`include "lisc_regs.vh"

module lisc_port #(
  parameter [`LISC_TMR_W-1:0] PWR_DELAY_CYC = `LISC_PWR_DELAY_MS * 1000 * `LISC_CLK_MHZ,
  parameter [`LISC_TMR_W-1:0] CAL_LIMIT_CYC = `LISC_CAL_LIMIT_MS * 1000 * `LISC_CLK_MHZ,
  parameter [`LISC_TMR_W-1:0] CAL_LEN_CYC = `LISC_CAL_LEN
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // serial port pins
  input wire port_select_n,
  input wire ser_clock,
  input wire ser_in,
  input wire output_edge_sel,
  output reg ser_out,
  output reg ser_out_oe,
  // open-drain alarm pin
  output reg alarm_int_out,
  output reg alarm_int_oe,
  // line status from receiver and driver monitor
  input wire signal_absent_in,
  input wire driver_fault_in,
  output reg signal_absent,
  output reg driver_fault_monitor,
  // mode and reset pins
  input wire host_mode,
  input wire line_loop_pin,
  input wire framer_loop_pin,
  // power and reference clocks
  input wire power_good,
  input wire xtal_running,
  input wire osc_disabled,
  input wire alt_ref_clock,
  input wire tx_clock,
  // control outputs
  output reg [2:0] cable_reach_sel,
  output reg line_side_loopback,
  output reg framer_side_loopback,
  output reg send_all_ones,
  output reg factory_test,
  output reg osc_center,
  output reg cal_busy,
  output reg cal_late
);

  // ----------
  // input synchronisation
  // ----------
  wire [`LISC_SYNC_W-1:0] s;

  lisc_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({tx_clock, alt_ref_clock, osc_disabled, xtal_running, power_good,
               framer_loop_pin, line_loop_pin, host_mode, driver_fault_in,
               signal_absent_in, output_edge_sel, ser_in, ser_clock, port_select_n}),
    .sync_out(s)
  );

  wire sel_n_s = s[`LISC_S_SEL_N];
  wire sclk_s = s[`LISC_S_SCLK];
  wire sin_s = s[`LISC_S_SIN];
  wire edge_s = s[`LISC_S_EDGE];
  wire los_s = s[`LISC_S_LOS];
  wire dpm_s = s[`LISC_S_DPM];

  // ----------
  // serial framing
  // ----------
  reg sel_prev_reg;
  reg sclk_prev_reg;
  reg active_reg;
  reg [`LISC_CNT_W-1:0] cnt_reg;
  reg [7:0] cmd_reg;
  reg [7:0] wdata_reg;
  reg [7:0] rd_reg;
  reg rd_en_reg;
  reg wr_en_reg;
  reg wr_commit_reg;
  reg [7:0] commit_data_reg;

  wire sclk_rise = sclk_s & ~sclk_prev_reg;
  wire sclk_fall = ~sclk_s & sclk_prev_reg;
  wire sel_fall = sel_prev_reg & ~sel_n_s;
  wire [7:0] cmd_next = {sin_s, cmd_reg[7:1]};
  wire [7:0] wdata_next = {sin_s, wdata_reg[7:1]};
  wire addr_hit = (cmd_next[`LISC_CMD_ADDR_HI:`LISC_CMD_ADDR_LO] == `LISC_REG_ADDR);
  wire [7:0] status_byte;

  // bit counter, shift registers, decode and write commit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      active_reg <= 1'b0;
      cnt_reg <= {`LISC_CNT_W{1'b0}};
      cmd_reg <= 8'h00;
      wdata_reg <= 8'h00;
      rd_reg <= 8'h00;
      rd_en_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_commit_reg <= 1'b0;
      commit_data_reg <= 8'h00;
    end else begin
      sel_prev_reg <= sel_n_s;
      sclk_prev_reg <= sclk_s;
      wr_commit_reg <= 1'b0;
      if (sel_n_s) begin
        // select high ends any transfer at once
        active_reg <= 1'b0;
        rd_en_reg <= 1'b0;
        wr_en_reg <= 1'b0;
      end else if (sel_fall) begin
        active_reg <= 1'b1;
        cnt_reg <= {`LISC_CNT_W{1'b0}};
        rd_en_reg <= 1'b0;
        wr_en_reg <= 1'b0;
      end else if (active_reg && sclk_rise) begin
        if (cnt_reg != `LISC_CNT_MAX) begin
          cnt_reg <= cnt_reg + 5'd1;
        end
        if (cnt_reg <= `LISC_CNT_CMD_LAST) begin
          cmd_reg <= cmd_next;
        end else if (cnt_reg <= `LISC_CNT_WR_LAST) begin
          wdata_reg <= wdata_next;
        end
        if (cnt_reg == `LISC_CNT_CMD_LAST) begin
          // last bit of the command byte is ignored
          rd_en_reg <= addr_hit & cmd_next[`LISC_CMD_RD_BIT];
          wr_en_reg <= addr_hit & ~cmd_next[`LISC_CMD_RD_BIT];
          rd_reg <= status_byte;
        end
        if (cnt_reg == `LISC_CNT_WR_LAST && wr_en_reg) begin
          // only a full byte to the right address lands
          wr_commit_reg <= 1'b1;
          commit_data_reg <= wdata_next;
        end
      end
    end
  end

  // ----------
  // read data output
  // ----------
  // edge select 1: change on falling, valid at rising; 0: the reverse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_out <= 1'b0;
      ser_out_oe <= 1'b0;
    end else if (sel_n_s || !active_reg || !rd_en_reg) begin
      ser_out_oe <= 1'b0; // idle, write or no match
    end else if ((edge_s && sclk_fall) || (!edge_s && sclk_rise)) begin
      if (cnt_reg >= `LISC_CNT_RD_FIRST && cnt_reg < `LISC_CNT_RD_END) begin
        ser_out <= rd_reg[cnt_reg[2:0]];
        ser_out_oe <= 1'b1;
      end else if (cnt_reg >= `LISC_CNT_RD_END) begin
        ser_out_oe <= 1'b0; // bit 7 hold ends at fall 16 or rise 17
      end
    end
  end

  // ----------
  // reset requests
  // ----------
  reg [`LISC_CNT_W-1:0] pin_cnt_reg;
  reg soft_rst_reg;
  wire both_pins = s[`LISC_S_LPIN] & s[`LISC_S_FPIN] & ~s[`LISC_S_HOST];
  wire host_rst = wr_commit_reg & commit_data_reg[`LISC_B_LINE_LB] & commit_data_reg[`LISC_B_FRM_LB];

  // pin request must last the minimum width; reset fires as it falls
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_cnt_reg <= {`LISC_CNT_W{1'b0}};
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= host_rst;
      if (both_pins) begin
        if (pin_cnt_reg != `LISC_PIN_RST_CYC) begin
          pin_cnt_reg <= pin_cnt_reg + 5'd1;
        end
      end else begin
        pin_cnt_reg <= {`LISC_CNT_W{1'b0}};
        if (pin_cnt_reg == `LISC_PIN_RST_CYC) begin
          soft_rst_reg <= 1'b1;
        end
      end
    end
  end

  // ----------
  // control register and alarm events
  // ----------
  reg [2:0] reach_reg;
  reg line_lb_reg;
  reg frm_lb_reg;
  reg ones_reg;
  reg los_mask_reg;
  reg dpm_mask_reg;
  reg los_evt_reg;
  reg dpm_evt_reg;
  reg los_prev_reg;
  reg dpm_prev_reg;
  wire los_chg = (los_s != los_prev_reg) & ~los_mask_reg;
  wire dpm_chg = (dpm_s != dpm_prev_reg) & ~dpm_mask_reg;
  wire clr_los = wr_commit_reg & commit_data_reg[`LISC_B_CLR_LOS];
  wire driver_fault_clear = wr_commit_reg & commit_data_reg[`LISC_B_DRIVER_FAULT_CLEAR];
  localparam [7:0] CTRL_RST = `LISC_CTRL_RESET;

  // status and loopback fields returned on a read
  wire any_evt = los_evt_reg | dpm_evt_reg;
  wire st5 = any_evt ? 1'b1 : line_lb_reg;
  wire st6 = any_evt ? los_evt_reg : frm_lb_reg;
  wire st7 = any_evt ? dpm_evt_reg : ones_reg;
  assign status_byte = {st7, st6, st5, reach_reg, dpm_s, 1'b0};

  // a change arriving with its clear keeps the event pending
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reach_reg <= 3'h0;
      line_lb_reg <= 1'b0;
      frm_lb_reg <= 1'b0;
      ones_reg <= 1'b0;
      los_mask_reg <= 1'b0;
      dpm_mask_reg <= 1'b0;
      los_evt_reg <= 1'b0;
      dpm_evt_reg <= 1'b0;
      los_prev_reg <= 1'b0;
      dpm_prev_reg <= 1'b0;
    end else begin
      los_prev_reg <= los_s;
      dpm_prev_reg <= dpm_s;
      if (soft_rst_reg) begin
        {ones_reg, frm_lb_reg, line_lb_reg, reach_reg} <= CTRL_RST[`LISC_B_ALL_ONES:`LISC_B_REACH_LO];
        los_mask_reg <= 1'b0;
        dpm_mask_reg <= 1'b0;
        los_evt_reg <= 1'b0;
        dpm_evt_reg <= 1'b0;
      end else begin
        // only a write clears the events; reads leave them
        los_evt_reg <= los_chg | (los_evt_reg & ~clr_los);
        dpm_evt_reg <= dpm_chg | (dpm_evt_reg & ~driver_fault_clear);
        if (wr_commit_reg && !host_rst) begin
          reach_reg <= commit_data_reg[`LISC_B_REACH_HI:`LISC_B_REACH_LO];
          line_lb_reg <= commit_data_reg[`LISC_B_LINE_LB];
          frm_lb_reg <= commit_data_reg[`LISC_B_FRM_LB];
          ones_reg <= commit_data_reg[`LISC_B_ALL_ONES];
          los_mask_reg <= commit_data_reg[`LISC_B_CLR_LOS];
          dpm_mask_reg <= commit_data_reg[`LISC_B_DRIVER_FAULT_CLEAR];
        end
      end
    end
  end

  // ----------
  // reference clock presence
  // ----------
  // lane 0 watches the alternate reference, lane 1 the transmit clock
  wire [1:0] ref_lvl = {s[`LISC_S_TXCLK], s[`LISC_S_ALTREF]};
  wire [1:0] ref_ok;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ref
      reg lvl_prev_reg;
      reg [7:0] idle_reg;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          lvl_prev_reg <= 1'b0;
          idle_reg <= `LISC_REF_GONE;
        end else begin
          lvl_prev_reg <= ref_lvl[g];
          if (ref_lvl[g] & ~lvl_prev_reg) begin
            idle_reg <= 8'h00;
          end else if (idle_reg != `LISC_REF_GONE) begin
            idle_reg <= idle_reg + 8'h01;
          end
        end
      end
      assign ref_ok[g] = (idle_reg != `LISC_REF_GONE);
    end
  endgenerate

  wire rx_ref_ok = s[`LISC_S_OSCDIS] ? ref_ok[0] : s[`LISC_S_XTAL];
  wire refs_ok = rx_ref_ok & ref_ok[1];

  // ----------
  // power-up delay and calibration
  // ----------
  reg [1:0] state_reg;
  reg [`LISC_TMR_W-1:0] tmr_reg;
  reg [`LISC_TMR_W-1:0] cal_reg;
  reg force_los_reg;

  // calibration length is a model figure; the limit only flags lateness
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `LISC_ST_WAIT;
      tmr_reg <= {`LISC_TMR_W{1'b0}};
      cal_reg <= {`LISC_TMR_W{1'b0}};
      force_los_reg <= 1'b1;
      osc_center <= 1'b1;
      cal_busy <= 1'b0;
      cal_late <= 1'b0;
    end else if (soft_rst_reg) begin
      state_reg <= `LISC_ST_CAL;
      tmr_reg <= {`LISC_TMR_W{1'b0}};
      cal_reg <= {`LISC_TMR_W{1'b0}};
      force_los_reg <= 1'b1;
      osc_center <= 1'b1;
      cal_busy <= 1'b1;
      cal_late <= 1'b0;
    end else begin
      case (state_reg)
        `LISC_ST_WAIT: begin
          if (!s[`LISC_S_PGOOD]) begin
            tmr_reg <= {`LISC_TMR_W{1'b0}};
          end else if (tmr_reg >= PWR_DELAY_CYC - 21'd1) begin
            state_reg <= `LISC_ST_CAL;
            tmr_reg <= {`LISC_TMR_W{1'b0}};
            cal_busy <= 1'b1;
          end else begin
            tmr_reg <= tmr_reg + 21'd1;
          end
        end
        `LISC_ST_CAL: begin
          if (tmr_reg != CAL_LIMIT_CYC) begin
            tmr_reg <= tmr_reg + 21'd1;
          end else begin
            cal_late <= 1'b1;
          end
          if (refs_ok) begin
            cal_reg <= cal_reg + 21'd1;
          end
          if (cal_reg >= CAL_LEN_CYC - 21'd1) begin
            state_reg <= `LISC_ST_RUN;
            cal_busy <= 1'b0;
            osc_center <= 1'b0;
            force_los_reg <= 1'b0;
          end
        end
        `LISC_ST_RUN: begin
          state_reg <= `LISC_ST_RUN;
        end
        default: begin
          state_reg <= `LISC_ST_WAIT;
        end
      endcase
    end
  end

  // ----------
  // registered outputs
  // ----------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_int_out <= 1'b0;
      alarm_int_oe <= 1'b0;
      signal_absent <= 1'b1;
      driver_fault_monitor <= 1'b0;
      cable_reach_sel <= 3'h0;
      line_side_loopback <= 1'b0;
      framer_side_loopback <= 1'b0;
      send_all_ones <= 1'b0;
      factory_test <= 1'b0;
    end else begin
      alarm_int_out <= 1'b0; // open drain only ever pulls low
      alarm_int_oe <= any_evt;
      signal_absent <= los_s | force_los_reg;
      driver_fault_monitor <= dpm_s;
      cable_reach_sel <= reach_reg;
      line_side_loopback <= line_lb_reg;
      framer_side_loopback <= frm_lb_reg;
      send_all_ones <= ones_reg;
      factory_test <= line_lb_reg & ones_reg;
    end
  end

endmodule // lisc_port
`default_nettype wire

// ---- src/lisc_sync.v ----
// two-flop synchroniser bank for all asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
`include "lisc_regs.vh"

module lisc_sync (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // asynchronous lanes in, synchronised lanes out
  input wire [`LISC_SYNC_W-1:0] async_in,
  output wire [`LISC_SYNC_W-1:0] sync_out
);

  reg [`LISC_SYNC_W-1:0] meta_reg;
  reg [`LISC_SYNC_W-1:0] sync_reg;

  // first stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < `LISC_SYNC_W; i = i + 1) begin : g_lane
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_reg;

endmodule // lisc_sync
`default_nettype wire

// ---- verification/lisc_host.sv ----
// host serial port model: select, parked link clock, data out, read capture
`timescale 1ns/1ns
`default_nettype none
module lisc_host (
  // serial pins towards the port
  output logic port_select_n,
  output logic ser_clock,
  output logic ser_in,
  input wire logic ser_out,
  input wire logic ser_out_oe,
  // captured read frame towards the bench
  output logic rd_strobe,
  output logic [16:0] rd_data
);
  localparam int HALF = 40;

  // idle: select high, link clock parked low between frames
  initial begin
    port_select_n = 1'b1;
    ser_clock = 1'b0;
    ser_in = 1'b0;
    rd_strobe = 1'b0;
    rd_data = 17'h0;
  end

  // one frame; cap[15:8] enables seen, cap[7:0] bits, cap[16] enable after hold
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int nb, input logic es);
    logic [16:0] cap;
    int i;
    cap = 17'h0;
    port_select_n = 1'b0;
    #HALF;
    for (i = 0; i < nb; i++) begin
      ser_in = (i < 8) ? cmd[i] : wd[i-8];
      #HALF ser_clock = 1'b1;
      if (i >= 8 && es) {cap[i], cap[i-8]} = {ser_out_oe, ser_out_oe & ser_out};
      #HALF ser_clock = 1'b0;
      if (i >= 8 && !es) {cap[i], cap[i-8]} = {ser_out_oe, ser_out_oe & ser_out};
    end
    // with falling-edge data the last bit lives until a 17th rise
    if (cmd[0] && !es) begin
      #HALF ser_clock = 1'b1;
      #HALF ser_clock = 1'b0;
    end
    #60 cap[16] = ser_out_oe;
    port_select_n = 1'b1;
    ser_in = ~ser_in;
    if (cmd[0] && nb == 16) begin
      rd_data = cap;
      rd_strobe = 1'b1;
      #10 rd_strobe = 1'b0;
    end
    #(2*HALF);
  endtask
endmodule // lisc_host
`default_nettype wire

// ---- verification/lisc_port_assertions.sv ----
// assertion checker bound to the serial control port
`timescale 1ns/1ns
`default_nettype none
`include "lisc_regs.vh"
module lisc_port_chk #(
  parameter [`LISC_TMR_W-1:0] PWR_DELAY_CYC = 21'h32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched inputs
  input wire logic port_select_n,
  input wire logic driver_fault_in,
  input wire logic power_good,
  input wire logic host_mode,
  // watched outputs
  input wire logic ser_out_oe,
  input wire logic alarm_int_out,
  input wire logic alarm_int_oe,
  input wire logic driver_fault_monitor,
  input wire logic signal_absent,
  input wire logic line_side_loopback,
  input wire logic send_all_ones,
  input wire logic factory_test,
  input wire logic osc_center,
  input wire logic cal_busy
);
  logic [`LISC_TMR_W-1:0] pg_cnt;
  logic [3:0] idle_cnt;

  // saturating counters: supply-good time and select-idle time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_cnt <= '0;
      idle_cnt <= 4'h0;
    end else begin
      if (power_good && pg_cnt != '1) pg_cnt <= pg_cnt + 1'b1;
      if (!port_select_n) idle_cnt <= 4'h0;
      else if (idle_cnt != 4'hf) idle_cnt <= idle_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // five samples cover the two-flop sync plus the output register
  sequence s_sel_idle; port_select_n [*5]; endsequence
  sequence s_flt_hi; driver_fault_in [*5]; endsequence
  sequence s_flt_lo; !driver_fault_in [*5]; endsequence
  sequence s_test_req; (line_side_loopback && send_all_ones) [*2]; endsequence

  property p_oe_idle; s_sel_idle |-> !ser_out_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("ser_out driven while idle");
  property p_oe_rise; $rose(ser_out_oe) |-> !port_select_n; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("ser_out driven outside frame");
  property p_flt_hi; s_flt_hi |-> driver_fault_monitor; endproperty
  a_flt_hi: assert property (p_flt_hi) else $error("fault monitor missed high");
  property p_flt_lo; s_flt_lo |-> !driver_fault_monitor; endproperty
  a_flt_lo: assert property (p_flt_lo) else $error("fault monitor missed low");
  property p_alarm_pin; alarm_int_out == 1'b0; endproperty
  a_alarm_pin: assert property (p_alarm_pin) else $error("open-drain alarm drives high");
  // alarm may only drop at a clearing write, i.e. during or just after a frame
  property p_alarm_hold; $fell(alarm_int_oe) && host_mode |-> idle_cnt < 4'ha; endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped without write");
  property p_cal_delay; $rose(cal_busy) |-> pg_cnt >= PWR_DELAY_CYC; endproperty
  a_cal_delay: assert property (p_cal_delay) else $error("calibration before power delay");
  property p_osc_loss; osc_center [*2] |-> signal_absent; endproperty
  a_osc_loss: assert property (p_osc_loss) else $error("loss not forced during reset");
  property p_test_on; s_test_req |-> factory_test; endproperty
  a_test_on: assert property (p_test_on) else $error("test mode missing");
  property p_test_off; !line_side_loopback [*2] |-> !factory_test; endproperty
  a_test_off: assert property (p_test_off) else $error("test mode without loopback");
endmodule // lisc_port_chk

bind lisc_port lisc_port_chk #(.PWR_DELAY_CYC(PWR_DELAY_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .port_select_n(port_select_n), .driver_fault_in(driver_fault_in),
  .power_good(power_good), .host_mode(host_mode), .ser_out_oe(ser_out_oe), .alarm_int_out(alarm_int_out),
  .alarm_int_oe(alarm_int_oe), .driver_fault_monitor(driver_fault_monitor), .signal_absent(signal_absent),
  .line_side_loopback(line_side_loopback), .send_all_ones(send_all_ones), .factory_test(factory_test),
  .osc_center(osc_center), .cal_busy(cal_busy)
);
`default_nettype wire

// ---- verification/lisc_port_tb.sv ----
// self-checking bench for the serial control port
`timescale 1ns/1ns
`default_nettype none
`include "lisc_regs.vh"
module lisc_port_tb;
  logic clk, rst_n, port_select_n, ser_clock, ser_in, output_edge_sel, ser_out, ser_out_oe;
  logic alarm_int_out, alarm_int_oe, signal_absent_in, driver_fault_in, signal_absent;
  logic driver_fault_monitor, host_mode, line_loop_pin, framer_loop_pin, power_good;
  logic alt_ref_clock, tx_clock, line_side_loopback, framer_side_loopback, send_all_ones;
  logic factory_test, osc_center, cal_busy, cal_late, rd_strobe, ref_on, osc_disabled, xtal_running;
  logic [2:0] cable_reach_sel;
  logic [16:0] rd_data;
  logic [16:0] exp_q[$];
  logic [31:0] rnd;
  logic [7:0] w;
  int fails, num_checks, k;

  // short power delay and calibration keep the run brief
  lisc_port #(.PWR_DELAY_CYC(21'h32), .CAL_LIMIT_CYC(21'h7d0), .CAL_LEN_CYC(21'h20)) i_lisc_port (
    .clk(clk), .rst_n(rst_n), .port_select_n(port_select_n), .ser_clock(ser_clock), .ser_in(ser_in),
    .output_edge_sel(output_edge_sel), .ser_out(ser_out), .ser_out_oe(ser_out_oe),
    .alarm_int_out(alarm_int_out), .alarm_int_oe(alarm_int_oe), .signal_absent_in(signal_absent_in),
    .driver_fault_in(driver_fault_in), .signal_absent(signal_absent), .driver_fault_monitor(driver_fault_monitor),
    .host_mode(host_mode), .line_loop_pin(line_loop_pin), .framer_loop_pin(framer_loop_pin),
    .power_good(power_good), .xtal_running(xtal_running), .osc_disabled(osc_disabled), .alt_ref_clock(alt_ref_clock),
    .tx_clock(tx_clock), .cable_reach_sel(cable_reach_sel), .line_side_loopback(line_side_loopback),
    .framer_side_loopback(framer_side_loopback), .send_all_ones(send_all_ones), .factory_test(factory_test),
    .osc_center(osc_center), .cal_busy(cal_busy), .cal_late(cal_late));

  lisc_host u_host (.port_select_n(port_select_n), .ser_clock(ser_clock), .ser_in(ser_in), .ser_out(ser_out),
    .ser_out_oe(ser_out_oe), .rd_strobe(rd_strobe), .rd_data(rd_data));

  // system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // reference clocks; the transmit one can be held to starve calibration
  initial begin
    alt_ref_clock = 1'b0;
    tx_clock = 1'b0;
    forever begin
      #50 alt_ref_clock = ~alt_ref_clock;
      if (ref_on) tx_clock = ~tx_clock;
    end
  end

  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic wr(input logic [7:0] d);
    u_host.xfer({1'b0, `LISC_REG_ADDR, 1'b0}, d, 16, output_edge_sel);
  endtask

  // the note goes in before the frame so the watcher finds it
  task automatic rd(input logic [7:0] e);
    exp_q.push_back({1'b0, 8'hff, e});
    u_host.xfer({1'b0, `LISC_REG_ADDR, 1'b1}, 8'h00, 16, output_edge_sel);
  endtask

  // bounded wait for calibration to finish
  task automatic wait_cal();
    int n;
    for (n = 0; n < 3000 && (osc_center !== 1'b0 || cal_busy !== 1'b0); n++) @(posedge clk);
    if (n == 3000) begin
      fails++;
      $display("[ERR] calibration expected done seen busy");
      tally_and_finish();
    end
    #1;
  endtask

  // watcher: each captured read frame against the oldest note
  always @(posedge rd_strobe) begin
    if (exp_q.size() == 0) check("unexpected read", 17'h1, 17'h0);
    else check("read frame", rd_data, exp_q.pop_front());
  end

  // watchdog
  initial begin
    #1000000;
    fails++;
    $display("[ERR] run expected end seen timeout");
    tally_and_finish();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    power_good = 1'b0;
    ref_on = 1'b0;
    output_edge_sel = 1'b1;
    host_mode = 1'b1;
    xtal_running = 1'b1;
    osc_disabled = 1'b0;
    line_loop_pin = 1'b0;
    framer_loop_pin = 1'b0;
    signal_absent_in = 1'b0;
    driver_fault_in = 1'b0;
    fails = 0;
    num_checks = 0;
    rnd = 32'h0000600e;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    check("reset state", {cable_reach_sel, line_side_loopback, framer_side_loopback, send_all_ones,
      signal_absent, osc_center, cal_busy}, 17'h6);
    power_good = 1'b1;
    repeat (40) @(posedge clk);
    #1 check("cal in power delay", cal_busy, 17'h0);
    repeat (30) @(posedge clk);
    #1 check("cal started", cal_busy, 17'h1);
    repeat (300) @(posedge clk);
    #1 check("cal without tx ref", osc_center, 17'h1);
    ref_on = 1'b1;
    wait_cal();
    check("cal late and loss", {cal_late, signal_absent}, 17'h0);
    wr(8'h03);
    rd(8'h00);
    // random settings, both output edges, clears held so no events
    for (k = 0; k < 8; k++) begin
      output_edge_sel = k[0];
      rnd = xs(rnd);
      w = {rnd[7:2], 2'b11};
      if (w[6:5] == 2'b11) w[6] = 1'b0;
      wr(w);
      check("controls", {cable_reach_sel, line_side_loopback, framer_side_loopback, send_all_ones,
        factory_test}, {w[4:2], w[5], w[6], w[7], w[5] & w[7]});
      rd(w & 8'hfc);
    end
    // events: raise, read twice, clear one, clear both, masked change, unmask
    output_edge_sel = 1'b1;
    wr(8'h00);
    driver_fault_in = 1'b1;
    repeat (10) @(posedge clk);
    #1 check("alarm on fault", alarm_int_oe, 17'h1);
    rd(8'ha2);
    rd(8'ha2);
    check("alarm after reads", alarm_int_oe, 17'h1);
    signal_absent_in = 1'b1;
    repeat (10) @(posedge clk);
    #1 rd(8'he2);
    wr(8'h01);
    rd(8'ha2);
    wr(8'h03);
    check("alarm cleared", alarm_int_oe, 17'h0);
    driver_fault_in = 1'b0;
    repeat (10) @(posedge clk);
    #1 check("alarm while masked", alarm_int_oe, 17'h0);
    rd(8'h00);
    wr(8'h00);
    driver_fault_in = 1'b1;
    repeat (10) @(posedge clk);
    #1 check("alarm unmasked", alarm_int_oe, 17'h1);
    // foreign address write and read, cut-short write, ignored top bit
    wr(8'h1f);
    u_host.xfer(8'h22, 8'h00, 16, 1'b1);
    exp_q.push_back(17'h0);
    u_host.xfer(8'h23, 8'h00, 16, 1'b1);
    u_host.xfer(8'h20, 8'h00, 12, 1'b1);
    check("reach kept", cable_reach_sel, 17'h7);
    u_host.xfer(8'ha0, 8'h0f, 16, 1'b1);
    check("top bit ignored", cable_reach_sel, 17'h3);
    // soft reset, transmit clock stopped, receive ref from the alternate clock
    ref_on = 1'b0;
    osc_disabled = 1'b1;
    xtal_running = 1'b0;
    repeat (300) @(posedge clk);
    #1 wr(8'h60);
    check("soft reset", {cable_reach_sel, line_side_loopback, framer_side_loopback,
      osc_center, signal_absent}, 17'h3);
    repeat (2100) @(posedge clk);
    #1 check("cal late", {cal_late, cal_busy}, 17'h3);
    ref_on = 1'b1;
    wait_cal();
    wr(8'h03);
    // pin reset: too short a request, then a long one
    host_mode = 1'b0;
    line_loop_pin = 1'b1;
    framer_loop_pin = 1'b1;
    #100 line_loop_pin = 1'b0;
    framer_loop_pin = 1'b0;
    #200 check("short pin request", osc_center, 17'h0);
    line_loop_pin = 1'b1;
    framer_loop_pin = 1'b1;
    #300 line_loop_pin = 1'b0;
    framer_loop_pin = 1'b0;
    #200 check("pin reset", {osc_center, signal_absent}, 17'h3);
    wait_cal();
    tally_and_finish();
  end
endmodule // lisc_port_tb
`default_nettype wire
